// ### rtl/gauge_status_consts.vh
// Purpose: Named constants for the gauge and error status summary block
// Assumes: 16-bit status and mask registers, 250 MHz ref_clk
// Notes: Definitions only
`ifndef GAUGE_STATUS_CONSTS_VH
`define GAUGE_STATUS_CONSTS_VH
`define REG_W 16
`define IDX_W 4
`define REG_ZERO 16'h0000
`define REG_ONES 16'hffff
// Implemented gauge condition bits: 0-7, 9, 10, 13, 14
`define GAUGE_USED 16'h66ff
`define BIT_ION_LOCK 0
`define BIT_ION_RANGE 1
`define BIT_ION_FAULT 2
`define BIT_ION_OVER 3
`define BIT_AN1 4
`define BIT_AN2 5
`define BIT_AN3 6
`define BIT_AN4 7
`define BIT_TG1_RANGE 9
`define BIT_TG1_FAULT 10
`define BIT_TG2_RANGE 13
`define BIT_TG2_FAULT 14
// Gauge status bits with no condition attached
`define BIT_SPARE0 8
`define BIT_SPARE1 11
`define BIT_SPARE2 12
`define BIT_SPARE3 15
`define BIT_ONE 16'h0001
`define SPOLL_ERR 1
`define SPOLL_GAUGE 2
// Command codes on the decoded command port
`define CMD_W 3
`define CMD_NONE 3'h0
`define CMD_EMASK_SET 3'h1
`define CMD_EMASK_BIT 3'h2
`define CMD_EMASK_QRY 3'h3
`define CMD_GMASK_SET 3'h4
`define CMD_GMASK_BIT 3'h5
`define CMD_GMASK_QRY 3'h6
`define CMD_GFLAG_QRY 3'h7
// Re-assertion interval of a persisting condition, in microseconds
`define RESET_INTERVAL_US 500000
`define CLK_MHZ 250
`endif

// ### rtl/cond_sync.v
// Purpose: Two-stage synchroniser for the asynchronous gauge condition lines
// Assumes: Inputs come from outside the ref_clk domain
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module cond_sync (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Data
  input wire [15:0] async_in,
  output reg [15:0] sync_out
);
  reg [15:0] meta_r;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 16'h0000;
      sync_out <= 16'h0000;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### rtl/gauge_error_status_summary.v
// Purpose: Sticky gauge status flags, gauge and error enable masks, summary bits
// Assumes: Host commands arrive already parsed as a one-cycle strobe with code
// Notes: Queries answer one cycle later on rsp_valid with rsp_data
`timescale 1ns/100ps
`default_nettype none
`include "gauge_status_consts.vh"
// Operation
// RL1 - Whole error mask write loads value
// RL2 - Indexed error mask write sets one bit
// RL3 - Error mask query returns whole mask
// RL4 - Indexed error mask query returns one bit
// RL5 - Error summary when error flags meet mask
// RL6 - Service request when summary and poll enable
// RL7 - Host clears error flags by reading them
// RL8 - Gauge flag query returns whole register
// RL9 - Indexed gauge flag query returns one bit
// RL10 - Whole gauge query clears all flags
// RL11 - Indexed gauge query clears only that bit
// RL12 - Ion gauge conditions set bits 0-3
// RL13 - Analog range conditions set bits 4-7
// RL14 - First thermal gauge sets bits 9, 10
// RL15 - Second thermal gauge sets bits 13, 14
// RL16 - Flags stay set until read or clear
// RL17 - Persisting condition resets flag within 0.5 s
// RL18 - Gauge summary when gauge flags meet mask
// RL19 - Unused gauge bits always read zero
// RL20 - Summaries recomputed continuously from masks
module gauge_error_status_summary #(
  parameter [31:0] RESET_INTERVAL_CYC = `RESET_INTERVAL_US * `CLK_MHZ
) (
  // Clock and reset
  input wire ref_clk,
  input wire nrst,
  // Gauge conditions, asynchronous levels
  input wire ion_lockout_flag,
  input wire ion_range_flag,
  input wire ion_fault_flag,
  input wire ion_overpressure_flag,
  input wire analog_one_range_flag,
  input wire analog_two_range_flag,
  input wire analog_three_range_flag,
  input wire analog_four_range_flag,
  input wire thermal_gauge_one_range_flag,
  input wire thermal_gauge_one_fault_flag,
  input wire thermal_gauge_two_range_flag,
  input wire thermal_gauge_two_fault_flag,
  // Error status register value, from the error status block
  input wire [15:0] error_flags,
  input wire [7:0] poll_enable,
  // Clear-status command and power-on status clear
  input wire clear_status,
  input wire power_on_clear_en,
  // Parsed host command
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire cmd_indexed,
  input wire [3:0] cmd_index,
  input wire [15:0] cmd_value,
  // Query answer
  output reg rsp_valid,
  output reg [15:0] rsp_data,
  // Masks, gauge flags, summaries and service request
  output reg [15:0] error_interrupt_mask,
  output reg [15:0] gauge_interrupt_mask,
  output reg [15:0] gauge_condition_flags,
  output reg error_summary_bit,
  output reg gauge_summary_bit,
  output reg service_request
);
  wire [15:0] cond_raw;
  wire [15:0] cond_s;
  reg [15:0] emask_nxt;
  reg [15:0] gmask_nxt;
  reg [15:0] flags_nxt;
  reg [15:0] rd_clr;
  reg [15:0] set_mask;
  reg [31:0] tick_cnt_r;
  reg [15:0] seen_r;
  reg pon_done_r;
  reg [15:0] rsp_nxt;
  reg rsp_v_nxt;
  reg err_hit;
  reg gauge_hit;
  wire tick;

  function [15:0] one_hot;
    input [3:0] idx;
    begin
      one_hot = `REG_ZERO | (`BIT_ONE << idx);
    end
  endfunction

  // Any status bit that meets its enable
  function any_hit;
    input [15:0] status;
    input [15:0] enable;
    begin
      any_hit = |(status & enable);
    end
  endfunction

  function [15:0] bit_update;
    input [15:0] cur;
    input idx_mode;
    input [3:0] idx;
    input [15:0] val;
    reg [15:0] one;
    begin
      one = one_hot(idx);
      if (idx_mode)
        bit_update = val[0] ? (cur | one) : (cur & ~one);
      else
        bit_update = val;
    end
  endfunction

  function [15:0] query;
    input [15:0] cur;
    input idx_mode;
    input [3:0] idx;
    begin
      if (idx_mode)
        query = {15'h0000, cur[idx]};
      else
        query = cur;
    end
  endfunction

  assign cond_raw[`BIT_ION_LOCK] = ion_lockout_flag; // RL12
  assign cond_raw[`BIT_ION_RANGE] = ion_range_flag; // RL12
  assign cond_raw[`BIT_ION_FAULT] = ion_fault_flag; // RL12
  assign cond_raw[`BIT_ION_OVER] = ion_overpressure_flag; // RL12
  assign cond_raw[`BIT_AN1] = analog_one_range_flag; // RL13
  assign cond_raw[`BIT_AN2] = analog_two_range_flag; // RL13
  assign cond_raw[`BIT_AN3] = analog_three_range_flag; // RL13
  assign cond_raw[`BIT_AN4] = analog_four_range_flag; // RL13
  assign cond_raw[`BIT_SPARE0] = 1'b0; // RL19
  assign cond_raw[`BIT_TG1_RANGE] = thermal_gauge_one_range_flag; // RL14
  assign cond_raw[`BIT_TG1_FAULT] = thermal_gauge_one_fault_flag; // RL14
  assign cond_raw[`BIT_SPARE1] = 1'b0; // RL19
  assign cond_raw[`BIT_SPARE2] = 1'b0; // RL19
  assign cond_raw[`BIT_TG2_RANGE] = thermal_gauge_two_range_flag; // RL15
  assign cond_raw[`BIT_TG2_FAULT] = thermal_gauge_two_fault_flag; // RL15
  assign cond_raw[`BIT_SPARE3] = 1'b0; // RL19

  cond_sync u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(cond_raw),
    .sync_out(cond_s)
  );

  assign tick = (tick_cnt_r == RESET_INTERVAL_CYC - 32'h0000_0001);

  // A persisting condition sets its flag on a rising edge, or again at each
  // interval tick, so a read-cleared flag returns within the interval
  always @* begin
    set_mask = cond_s & (~seen_r | {`REG_W{tick}}) & `GAUGE_USED; // RL17
  end

  always @* begin
    emask_nxt = error_interrupt_mask;
    gmask_nxt = gauge_interrupt_mask;
    rd_clr = `REG_ZERO;
    rsp_nxt = `REG_ZERO;
    rsp_v_nxt = 1'b0;
    if (cmd_valid) begin
      case (cmd_code)
        `CMD_EMASK_SET: begin
          emask_nxt = cmd_value; // RL1
        end
        `CMD_EMASK_BIT: begin
          emask_nxt = bit_update(error_interrupt_mask, 1'b1, cmd_index, cmd_value); // RL2
        end
        `CMD_EMASK_QRY: begin
          rsp_nxt = query(error_interrupt_mask, cmd_indexed, cmd_index); // RL3 RL4
          rsp_v_nxt = 1'b1;
        end
        `CMD_GMASK_SET: begin
          gmask_nxt = cmd_value;
        end
        `CMD_GMASK_BIT: begin
          gmask_nxt = bit_update(gauge_interrupt_mask, 1'b1, cmd_index, cmd_value);
        end
        `CMD_GMASK_QRY: begin
          rsp_nxt = query(gauge_interrupt_mask, cmd_indexed, cmd_index);
          rsp_v_nxt = 1'b1;
        end
        `CMD_GFLAG_QRY: begin
          rsp_nxt = query(gauge_condition_flags, cmd_indexed, cmd_index); // RL8 RL9
          rsp_v_nxt = 1'b1;
          if (cmd_indexed)
            rd_clr = one_hot(cmd_index); // RL11
          else
            rd_clr = `REG_ONES; // RL10
        end
        default: begin
          rsp_v_nxt = 1'b0;
        end
      endcase
    end
    // Clear by read or clear-status; a simultaneous new event wins
    if (clear_status || (!pon_done_r && power_on_clear_en))
      rd_clr = `REG_ONES; // RL16
    flags_nxt = ((gauge_condition_flags & ~rd_clr) | set_mask) & `GAUGE_USED; // RL16 RL19
    // Summaries follow the next mask and flag values, so they move with them
    err_hit = any_hit(error_flags, emask_nxt); // RL5 RL20
    gauge_hit = any_hit(flags_nxt, gmask_nxt); // RL18 RL20
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0000_0000;
      seen_r <= `REG_ZERO;
      pon_done_r <= 1'b0;
      error_interrupt_mask <= `REG_ZERO;
      gauge_interrupt_mask <= `REG_ZERO;
      gauge_condition_flags <= `REG_ZERO;
      rsp_valid <= 1'b0;
      rsp_data <= `REG_ZERO;
      error_summary_bit <= 1'b0;
      gauge_summary_bit <= 1'b0;
      service_request <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
      seen_r <= cond_s;
      pon_done_r <= 1'b1;
      error_interrupt_mask <= emask_nxt;
      gauge_interrupt_mask <= gmask_nxt;
      gauge_condition_flags <= flags_nxt;
      rsp_valid <= rsp_v_nxt;
      rsp_data <= rsp_nxt;
      // Error flags are cleared by their own read query elsewhere, not here
      error_summary_bit <= err_hit; // RL5 RL20 RL7
      gauge_summary_bit <= gauge_hit; // RL18 RL20
      service_request <= (err_hit & poll_enable[`SPOLL_ERR]) |
                         (gauge_hit & poll_enable[`SPOLL_GAUGE]); // RL6
    end
  end
endmodule
`default_nettype wire

// ### testbench/gauge_sva.sv
// Purpose: Port assertions for the status summary block
// Assumes: One clock, reset asynchronous and active low
// Notes: Bound to every instance below
`timescale 1ns/100ps
`default_nettype none
module gauge_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Inputs
  input wire logic [15:0] error_flags,
  input wire logic [7:0] poll_enable,
  input wire logic clear_status,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [3:0] cmd_index,
  input wire logic [15:0] cmd_value,
  // Outputs
  input wire logic rsp_valid,
  input wire logic [15:0] error_interrupt_mask,
  input wire logic [15:0] gauge_interrupt_mask,
  input wire logic [15:0] gauge_condition_flags,
  input wire logic error_summary_bit,
  input wire logic gauge_summary_bit,
  input wire logic service_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  emask_load_a: assert property (
    cmd_valid && cmd_code == 3'h1 |=> error_interrupt_mask == $past(cmd_value)) else $error("load");
  emask_bit_a: assert property (cmd_valid && cmd_code == 3'h2 |=>
    error_interrupt_mask[$past(cmd_index)] == $past(cmd_value[0])) else $error("bit write");
  answer_cause_a: assert property (
    rsp_valid |-> $past(cmd_valid) && $past(cmd_code) inside {3'h3, 3'h6, 3'h7}) else $error("rsp");
  unused_zero_a: assert property (
    (gauge_condition_flags & 16'h9900) == 16'h0000) else $error("unused bit set");
  err_summary_a: assert property ($past(nrst) |->
    error_summary_bit == |($past(error_flags) & error_interrupt_mask)) else $error("err sum");
  gauge_summary_a: assert property (
    gauge_summary_bit == |(gauge_condition_flags & gauge_interrupt_mask)) else $error("gauge sum");
  srq_level_a: assert property ($past(nrst) |-> service_request ==
    (error_summary_bit && $past(poll_enable[1]) || gauge_summary_bit && $past(poll_enable[2])))
    else $error("srq");
  flags_sticky_a: assert property (
    $past(nrst) && !$past(cmd_valid) && !$past(clear_status) |->
    (gauge_condition_flags & $past(gauge_condition_flags)) == $past(gauge_condition_flags))
    else $error("flag lost");
endmodule
bind gauge_error_status_summary gauge_sva u_sva (.*);
`default_nettype wire

// ### testbench/gauge_host.sv
// Purpose: Host side issuing parsed status commands
// Assumes: Commands launched on the falling edge
// Notes: Released index and value fields are inverted; code and indexed flag are held
`timescale 1ns/100ps
`default_nettype none
module gauge_host (
  // Clock
  input wire logic ref_clk,
  // Command
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic cmd_indexed,
  output logic [3:0] cmd_index,
  output logic [15:0] cmd_value
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_indexed = 1'b0;
    cmd_index = 4'h0;
    cmd_value = 16'h0000;
  end
  task automatic send(input logic [2:0] c, input logic x, input logic [3:0] i, input logic [15:0] v);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_indexed = x;
    cmd_index = i;
    cmd_value = v;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_index = ~i;
    cmd_value = ~v;
  endtask
endmodule
`default_nettype wire

// ### testbench/gauge_error_status_summary_tb.sv
// Purpose: Self-checking bench for the status summary block
// Assumes: Short re-assertion interval of 16 cycles
// Notes: Answers are checked in the cycle they stand
`timescale 1ns/100ps
`default_nettype none
module gauge_error_status_summary_tb;
  typedef struct {logic [2:0] c; logic [3:0] i; logic [15:0] v; logic [15:0] e;} row_t;
  row_t rows[6] = '{'{3'h1, 4'h0, 16'hffff, 16'hffff}, '{3'h2, 4'hf, 16'h0000, 16'h7fff},
    '{3'h2, 4'h0, 16'h0000, 16'h7ffe}, '{3'h1, 4'h0, 16'h0030, 16'h0030},
    '{3'h4, 4'h0, 16'h0020, 16'h0020}, '{3'h5, 4'h9, 16'h0001, 16'h0220}};
  int pos[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 13, 14};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] cond = 12'h000;
  logic [15:0] error_flags = 16'h0000;
  logic [7:0] poll_enable = 8'h06;
  logic clear_status = 1'b0;
  wire cmd_valid, cmd_indexed, rsp_valid, error_summary_bit, gauge_summary_bit, service_request;
  wire [2:0] cmd_code;
  wire [3:0] cmd_index;
  wire [15:0] cmd_value, rsp_data, error_interrupt_mask, gauge_interrupt_mask, gauge_condition_flags;
  int num_errors = 0;
  int check_count = 0;
  gauge_host host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_indexed(cmd_indexed), .cmd_index(cmd_index), .cmd_value(cmd_value));
  gauge_error_status_summary #(.RESET_INTERVAL_CYC(32'h0000_0010)) dut (.ref_clk(ref_clk),
    .nrst(nrst),
    .ion_lockout_flag(cond[0]), .ion_range_flag(cond[1]), .ion_fault_flag(cond[2]),
    .ion_overpressure_flag(cond[3]), .analog_one_range_flag(cond[4]),
    .analog_two_range_flag(cond[5]), .analog_three_range_flag(cond[6]),
    .analog_four_range_flag(cond[7]), .thermal_gauge_one_range_flag(cond[8]),
    .thermal_gauge_one_fault_flag(cond[9]), .thermal_gauge_two_range_flag(cond[10]),
    .thermal_gauge_two_fault_flag(cond[11]), .error_flags(error_flags), .poll_enable(poll_enable),
    .clear_status(clear_status), .power_on_clear_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_indexed(cmd_indexed), .cmd_index(cmd_index),
    .cmd_value(cmd_value), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .error_interrupt_mask(error_interrupt_mask), .gauge_interrupt_mask(gauge_interrupt_mask),
    .gauge_condition_flags(gauge_condition_flags), .error_summary_bit(error_summary_bit),
    .gauge_summary_bit(gauge_summary_bit), .service_request(service_request));
  initial forever #2 ref_clk = ~ref_clk;
  task chk(input logic [16:0] s, input logic [16:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task q(input logic [2:0] c, input logic x, input logic [3:0] i, input logic [15:0] e);
    host.send(c, x, i, 16'h0000);
    chk({rsp_valid, rsp_data}, {1'b1, e});
  endtask
  task conclude;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    chk({rsp_valid, error_interrupt_mask | gauge_interrupt_mask | gauge_condition_flags}, 17'h0);
    foreach (rows[n]) begin
      host.send(rows[n].c, 1'b1, rows[n].i, rows[n].v);
      chk({1'b0, rows[n].c < 3'h4 ? error_interrupt_mask : gauge_interrupt_mask}, {1'b0, rows[n].e});
    end
    q(3'h3, 1'b0, 4'h0, 16'h0030);
    q(3'h3, 1'b1, 4'h4, 16'h0001);
    q(3'h3, 1'b1, 4'h0, 16'h0000);
    q(3'h6, 1'b1, 4'h9, 16'h0001);
    q(3'h6, 1'b0, 4'h0, 16'h0220);
    foreach (pos[k]) begin
      cond[k] = 1'b1;
      @(negedge ref_clk);
      cond[k] = 1'b0;
      repeat (5) @(negedge ref_clk);
      q(3'h7, 1'b0, 4'h0, 16'h0001 << pos[k]);
      chk({1'b0, gauge_condition_flags}, 17'h0);
    end
    cond = 12'h110;
    @(negedge ref_clk);
    cond = 12'h000;
    repeat (5) @(negedge ref_clk);
    q(3'h7, 1'b1, 4'h4, 16'h0001);
    chk({1'b0, gauge_condition_flags}, 17'h0200);
    clear_status = 1'b1;
    @(negedge ref_clk);
    clear_status = 1'b0;
    chk({1'b0, gauge_condition_flags}, 17'h0);
    cond[4] = 1'b1;
    repeat (5) @(negedge ref_clk);
    q(3'h7, 1'b0, 4'h0, 16'h0010);
    repeat (20) if (gauge_condition_flags[4] !== 1'b1) @(negedge ref_clk);
    chk({16'h0000, gauge_condition_flags[4]}, 17'h1);
    cond[4] = 1'b0;
    error_flags = 16'h0100;
    host.send(3'h2, 1'b0, 4'h8, 16'h0001);
    chk({15'h0000, error_summary_bit, service_request}, 17'h3);
    poll_enable = 8'h00;
    @(negedge ref_clk);
    chk({15'h0000, error_summary_bit, service_request}, 17'h2);
    host.send(3'h2, 1'b0, 4'h8, 16'h0000);
    chk({15'h0000, error_summary_bit, service_request}, 17'h0);
    error_flags = 16'h0000;
    poll_enable = 8'h04;
    cond[8] = 1'b1;
    @(negedge ref_clk);
    cond[8] = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk({15'h0000, gauge_summary_bit, service_request}, 17'h3);
    q(3'h7, 1'b0, 4'h0, 16'h0210);
    chk({15'h0000, gauge_summary_bit, service_request}, 17'h0);
    // Mid-run reset, then the first command after release and a void code
    nrst = 1'b0;
    @(negedge ref_clk);
    nrst = 1'b1;
    chk({rsp_valid, error_interrupt_mask | gauge_interrupt_mask | gauge_condition_flags}, 17'h0);
    host.send(3'h1, 1'b0, 4'h0, 16'h00a5);
    chk({1'b0, error_interrupt_mask}, 17'h00a5);
    host.send(3'h0, 1'b0, 4'h0, 16'hffff);
    chk({rsp_valid, rsp_data}, 17'h0);
    chk({1'b0, error_interrupt_mask}, 17'h00a5);
    conclude;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire
